// [verilog/acxu_exec.v]
// Execution datapath for add, add with carry, AND and subroutine call
`timescale 1ns/1ns
`default_nettype none
`include "acxu_defs.vh"

module acxu_exec (
   input  wire                    clk,
   input  wire                    arst_n,
   input  wire                    op_valid,
   input  wire [3:0]              op_code,
   input  wire [`ACXU_DW-1:0]     mem_rdata,
   input  wire [`ACXU_DW-1:0]     imm_data,
   input  wire [`ACXU_PCW-1:0]    call_target,
   input  wire [`ACXU_PCW-1:0]    pc_in,
   output wire                    op_ready,
   output reg  [`ACXU_DW-1:0]     acc_r,
   output reg                     zero_flag_r,
   output reg                     carry_flag_r,
   output reg                     half_carry_flag_r,
   output reg                     overflow_flag_r,
   output reg                     mem_we_r,
   output reg  [`ACXU_DW-1:0]     mem_wdata_r,
   output reg                     stack_push_r,
   output reg  [`ACXU_PCW-1:0]    stack_data_r,
   output reg                     pc_load_r,
   output reg  [`ACXU_PCW-1:0]    pc_target_r
);
   // ----------------------------------------
   // Operation decode helpers
   // ----------------------------------------
   localparam ST_IDLE  = 1'b0;
   localparam ST_CALL2 = 1'b1;

   reg                  state_r;
   reg                  state_nxt;
   reg [`ACXU_PCW-1:0]  tgt_hold_r;
   reg [`ACXU_PCW-1:0]  tgt_hold_nxt;
   reg [`ACXU_DW-1:0]   acc_nxt;
   reg                  zero_nxt;
   reg                  carry_nxt;
   reg                  half_carry_nxt;
   reg                  overflow_nxt;
   reg                  mem_we_nxt;
   reg [`ACXU_DW-1:0]   mem_wdata_nxt;
   reg                  stack_push_nxt;
   reg [`ACXU_PCW-1:0]  stack_data_nxt;
   reg                  pc_load_nxt;
   reg [`ACXU_PCW-1:0]  pc_target_nxt;

   function is_arith;
      input [3:0] op;
      begin
         is_arith = (op == `ACXU_OP_ADC_A) || (op == `ACXU_OP_ADC_M) ||
                    (op == `ACXU_OP_ADD_A) || (op == `ACXU_OP_ADD_I) ||
                    (op == `ACXU_OP_ADD_M);
      end
   endfunction

   function is_logic;
      input [3:0] op;
      begin
         is_logic = (op == `ACXU_OP_AND_A) || (op == `ACXU_OP_AND_I) ||
                    (op == `ACXU_OP_AND_M);
      end
   endfunction

   function to_mem;
      input [3:0] op;
      begin
         to_mem = (op == `ACXU_OP_ADC_M) || (op == `ACXU_OP_ADD_M) ||
                  (op == `ACXU_OP_AND_M);
      end
   endfunction

   function is_call;
      input [3:0] op;
      begin
         is_call = (op == `ACXU_OP_CALL);
      end
   endfunction

   // ----------------------------------------
   // Operand selection and adder
   // ----------------------------------------
   wire                op_go;
   wire                use_imm;
   wire                use_cin;
   wire [`ACXU_DW-1:0] opnd_b;
   wire [`ACXU_DW-1:0] add_sum;
   wire [`ACXU_DW-1:0] and_res;
   wire [`ACXU_DW-1:0] result;
   wire                add_c;
   wire                add_hc;
   wire                add_ov;

   assign op_go   = op_valid && op_ready;
   assign use_imm = (op_code == `ACXU_OP_ADD_I) || (op_code == `ACXU_OP_AND_I); // [RULE4] [RULE7]
   // Carry input only for the two with-carry forms; plain adds
   // and the immediate add always see a zero carry in
   assign use_cin = ((op_code == `ACXU_OP_ADC_A) ||
                     (op_code == `ACXU_OP_ADC_M)) &&
                    carry_flag_r;                  // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5]
   assign opnd_b  = use_imm ? imm_data : mem_rdata;
   assign and_res = acc_r & opnd_b;                             // [RULE6] [RULE7] [RULE8]
   assign result  = is_logic(op_code) ? and_res : add_sum;

   acxu_adder u_add (
      .a     (acc_r),
      .b     (opnd_b),
      .cin   (use_cin),
      .sum   (add_sum),
      .cout  (add_c),
      .hcout (add_hc),
      .ovf   (add_ov)
   );

   // Decoder may issue only while no call is in its second cycle
   assign op_ready = (state_r == ST_IDLE);                      // [RULE11]

   // ----------------------------------------
   // Call sequencing
   // ----------------------------------------
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (op_go && (op_code == `ACXU_OP_CALL)) begin
               state_nxt = ST_CALL2;                            // [RULE11]
            end
         end
         ST_CALL2: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // Accumulator and flag next values
   // ----------------------------------------
   // Arithmetic updates all four flags, AND only zero; a call,
   // a refused op or an unknown code leaves every one of them alone
   always @* begin
      acc_nxt        = acc_r;
      zero_nxt       = zero_flag_r;
      carry_nxt      = carry_flag_r;
      half_carry_nxt = half_carry_flag_r;
      overflow_nxt   = overflow_flag_r;
      if (op_go && (is_arith(op_code) || is_logic(op_code))) begin
         // Zero reflects the byte actually produced, wherever it goes
         zero_nxt = (result == `ACXU_ACC_RST);            // [RULE12]
         if (!to_mem(op_code)) begin
            acc_nxt = result;                  // [RULE1] [RULE3] [RULE4] [RULE6] [RULE7]
         end
      end
      if (op_go && is_arith(op_code)) begin
         carry_nxt      = add_c;                          // [RULE1] [RULE2] [RULE5]
         half_carry_nxt = add_hc;
         overflow_nxt   = add_ov;
      end
   end

   // ----------------------------------------
   // Write-back, push and load next values
   // ----------------------------------------
   // Push in the cycle after the taking edge, load one cycle later
   always @* begin
      mem_we_nxt     = op_go && to_mem(op_code);          // [RULE2] [RULE5] [RULE8]
      mem_wdata_nxt  = mem_wdata_r;
      stack_push_nxt = op_go && is_call(op_code);         // [RULE9]
      stack_data_nxt = stack_data_r;
      pc_load_nxt    = (state_r == ST_CALL2);             // [RULE10]
      pc_target_nxt  = pc_target_r;
      tgt_hold_nxt   = tgt_hold_r;
      if (op_go && to_mem(op_code)) begin
         mem_wdata_nxt = result;
      end
      if (op_go && is_call(op_code)) begin
         // Return address wraps at the top of program space
         stack_data_nxt = pc_in + `ACXU_PC_INC;           // [RULE9]
         // Target held over the busy slot; decoder may move on
         tgt_hold_nxt   = call_target;                    // [RULE10]
      end
      if (state_r == ST_CALL2) begin
         pc_target_nxt = tgt_hold_r;                      // [RULE10]
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // Sequencer, accumulator, flags and held target
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r           <= ST_IDLE;
         acc_r             <= `ACXU_ACC_RST;
         zero_flag_r       <= 1'b0;
         carry_flag_r      <= 1'b0;
         half_carry_flag_r <= 1'b0;
         overflow_flag_r   <= 1'b0;
         tgt_hold_r        <= `ACXU_PC_RST;
      end else begin
         state_r           <= state_nxt;
         acc_r             <= acc_nxt;
         zero_flag_r       <= zero_nxt;
         carry_flag_r      <= carry_nxt;
         half_carry_flag_r <= half_carry_nxt;
         overflow_flag_r   <= overflow_nxt;
         tgt_hold_r        <= tgt_hold_nxt;
      end
   end

   // Memory, stack and program counter strobes and data
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mem_we_r     <= 1'b0;
         mem_wdata_r  <= `ACXU_ACC_RST;
         stack_push_r <= 1'b0;
         stack_data_r <= `ACXU_PC_RST;
         pc_load_r    <= 1'b0;
         pc_target_r  <= `ACXU_PC_RST;
      end else begin
         mem_we_r     <= mem_we_nxt;
         mem_wdata_r  <= mem_wdata_nxt;
         stack_push_r <= stack_push_nxt;
         stack_data_r <= stack_data_nxt;
         pc_load_r    <= pc_load_nxt;
         pc_target_r  <= pc_target_nxt;
      end
   end
endmodule
`default_nettype wire

// [verilog/acxu_defs.vh]
// Constants for the add, AND and call execution unit
//
// Summary of operation
// RULE1: ADC to accumulator: acc+mem+carry, flags updated
// RULE2: ADC to memory: sum written back, accumulator kept
// RULE3: ADD memory to accumulator, no carry in
// RULE4: ADD immediate to accumulator, no carry in
// RULE5: ADD to memory, no carry in, flags updated
// RULE6: AND memory into accumulator, zero flag only
// RULE7: AND immediate into accumulator, zero flag only
// RULE8: AND into memory, accumulator kept, zero only
// RULE9: Call pushes program counter plus one
// RULE10: Call loads target address, flags untouched
// RULE11: Call takes two instruction cycles
// RULE12: Eight-bit data; standard zero/carry/half/overflow flags
`ifndef ACXU_DEFS_VH
`define ACXU_DEFS_VH

// ----------------------------------------
// Widths
// ----------------------------------------
`define ACXU_DW        8
`define ACXU_PCW       13

// ----------------------------------------
// Operation codes from the decoder
// ----------------------------------------
`define ACXU_OP_NOP    4'h0
`define ACXU_OP_ADC_A  4'h1
`define ACXU_OP_ADC_M  4'h2
`define ACXU_OP_ADD_A  4'h3
`define ACXU_OP_ADD_I  4'h4
`define ACXU_OP_ADD_M  4'h5
`define ACXU_OP_AND_A  4'h6
`define ACXU_OP_AND_I  4'h7
`define ACXU_OP_AND_M  4'h8
`define ACXU_OP_CALL   4'h9

// ----------------------------------------
// Reset values and call timing
// ----------------------------------------
`define ACXU_ACC_RST   8'h00
`define ACXU_PC_RST    13'h0000
`define ACXU_PC_INC    13'h0001
`define ACXU_CALL_CYC  2

`endif

// [verilog/acxu_adder.v]
// Eight-bit adder with carry, half-carry and overflow outputs
`timescale 1ns/1ns
`default_nettype none
`include "acxu_defs.vh"

module acxu_adder (
   input  wire [7:0] a,
   input  wire [7:0] b,
   input  wire       cin,
   output wire [7:0] sum,
   output wire       cout,
   output wire       hcout,
   output wire       ovf
);
   wire [4:0] lo;
   wire [4:0] hi;

   // Nibble-wise add exposes the bit 3 carry
   assign lo    = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
   assign hi    = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
   assign sum   = {hi[3:0], lo[3:0]};
   assign cout  = hi[4];                              // [RULE12]
   assign hcout = lo[4];                              // [RULE12]
   // Signed overflow: like-signed operands, unlike-signed sum
   assign ovf   = (a[7] == b[7]) && (sum[7] != a[7]); // [RULE12]
endmodule
`default_nettype wire

// [sim/acxu_exec_monitor.sv]
// Port checker for the add, AND and call execution unit
`timescale 1ns/1ns
`default_nettype none
`include "acxu_defs.vh"
module acxu_exec_monitor (
   input wire logic        clk,
   input wire logic        arst_n,
   input wire logic        op_valid,
   input wire logic        op_ready,
   input wire logic        mem_we_r,
   input wire logic        stack_push_r,
   input wire logic        pc_load_r,
   input wire logic        zero_flag_r,
   input wire logic        carry_flag_r,
   input wire logic        half_carry_flag_r,
   input wire logic        overflow_flag_r,
   input wire logic [3:0]  op_code,
   input wire logic [7:0]  mem_rdata,
   input wire logic [7:0]  acc_r,
   input wire logic [12:0] call_target,
   input wire logic [12:0] pc_in,
   input wire logic [12:0] stack_data_r,
   input wire logic [12:0] pc_target_r
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Taken operation and packed flags
   wire       tk = op_valid && op_ready;
   wire [3:0] fl = {overflow_flag_r, zero_flag_r, half_carry_flag_r, carry_flag_r};
   wire       cl = tk && op_code == `ACXU_OP_CALL;
   property p_call_ready; cl |=> !op_ready ##1 op_ready; endproperty
   a_call_ready: assert property (p_call_ready) else $error("call busy slot wrong");
   property p_call_push; cl |=> stack_push_r && stack_data_r == $past(pc_in) + 13'h0001;
   endproperty
   a_call_push: assert property (p_call_push) else $error("return address wrong");
   property p_call_load; cl |=> !pc_load_r ##1 pc_load_r && pc_target_r == $past(call_target, 2);
   endproperty
   a_call_load: assert property (p_call_load) else $error("call target wrong");
   property p_call_flags; cl |=> $stable(fl) && $stable(acc_r); endproperty
   a_call_flags: assert property (p_call_flags) else $error("call changed state");
   property p_and_flags;
      tk && op_code inside {`ACXU_OP_AND_A, `ACXU_OP_AND_I, `ACXU_OP_AND_M}
      |=> $stable({fl[3], fl[1:0]});
   endproperty
   a_and_flags: assert property (p_and_flags) else $error("AND touched flags");
   property p_and_zero; tk && op_code == `ACXU_OP_AND_A |=> zero_flag_r == (acc_r == 8'h00);
   endproperty
   a_and_zero: assert property (p_and_zero) else $error("AND zero flag wrong");
   property p_mem_acc;
      tk && op_code inside {`ACXU_OP_ADC_M, `ACXU_OP_ADD_M, `ACXU_OP_AND_M}
      |=> $stable(acc_r) && mem_we_r;
   endproperty
   a_mem_acc: assert property (p_mem_acc) else $error("memory op wrong");
   property p_add_acc;
      tk && op_code == `ACXU_OP_ADD_A |=> acc_r == $past(acc_r) + $past(mem_rdata);
   endproperty
   a_add_acc: assert property (p_add_acc) else $error("add sum wrong");
   property p_adc_acc;
      tk && op_code == `ACXU_OP_ADC_A
      |=> acc_r == $past(acc_r) + $past(mem_rdata) + $past(carry_flag_r);
   endproperty
   a_adc_acc: assert property (p_adc_acc) else $error("add with carry sum wrong");
   property p_refused; op_valid && !op_ready |=> $stable(acc_r) && $stable(fl); endproperty
   a_refused: assert property (p_refused) else $error("busy slot op took effect");
   property p_push_once; stack_push_r |=> !stack_push_r; endproperty
   a_push_once: assert property (p_push_once) else $error("push pulse too long");
   property p_load_once; pc_load_r |=> !pc_load_r; endproperty
   a_load_once: assert property (p_load_once) else $error("load pulse too long");
endmodule
bind acxu_exec acxu_exec_monitor u_mon (.clk(clk), .arst_n(arst_n), .op_valid(op_valid),
   .op_ready(op_ready), .mem_we_r(mem_we_r), .stack_push_r(stack_push_r),
   .pc_load_r(pc_load_r), .zero_flag_r(zero_flag_r), .carry_flag_r(carry_flag_r),
   .half_carry_flag_r(half_carry_flag_r), .overflow_flag_r(overflow_flag_r),
   .op_code(op_code), .mem_rdata(mem_rdata), .acc_r(acc_r), .call_target(call_target),
   .pc_in(pc_in), .stack_data_r(stack_data_r), .pc_target_r(pc_target_r));
`default_nettype wire

// [sim/acxu_mem_model.sv]
// Data memory byte model facing the execution unit
`timescale 1ns/1ns
`default_nettype none
module acxu_mem_model (
   input  wire       clk,
   input  wire       mem_we,
   input  wire [7:0] mem_wdata,
   input  wire       preset,
   input  wire [7:0] preset_val,
   output wire [7:0] mem_rdata
);
   reg [7:0] byte_r;
   // Write port, bench preset wins
   always @(posedge clk) begin
      if (preset)
         byte_r <= preset_val;
      else if (mem_we)
         byte_r <= mem_wdata;
   end
   assign mem_rdata = byte_r;
endmodule
`default_nettype wire

// [sim/acxu_exec_bench.sv]
// Self-checking bench for the execution unit
`timescale 1ns/1ns
`default_nettype none
`include "acxu_defs.vh"
module acxu_exec_bench;
   reg         clk = 0, arst_n = 0, op_valid = 0, preset = 0;
   reg  [3:0]  op_code = 4'h0;
   reg  [7:0]  imm_data = 8'h00, preset_val = 8'h00;
   reg  [12:0] call_target = 13'h0000, pc_in = 13'h0000;
   wire        op_ready, zf, cf, hf, vf, mem_we_r, stack_push_r, pc_load_r;
   wire [7:0]  acc_r, mem_rdata, mem_wdata_r;
   wire [12:0] stack_data_r, pc_target_r;
   integer     n_errors = 0, checked = 0;
   always #5 clk = ~clk;
   acxu_exec dut (.clk(clk), .arst_n(arst_n), .op_valid(op_valid), .op_code(op_code),
      .mem_rdata(mem_rdata), .imm_data(imm_data), .call_target(call_target), .pc_in(pc_in),
      .op_ready(op_ready), .acc_r(acc_r), .zero_flag_r(zf), .carry_flag_r(cf),
      .half_carry_flag_r(hf), .overflow_flag_r(vf), .mem_we_r(mem_we_r),
      .mem_wdata_r(mem_wdata_r), .stack_push_r(stack_push_r), .stack_data_r(stack_data_r),
      .pc_load_r(pc_load_r), .pc_target_r(pc_target_r));
   acxu_mem_model mem (.clk(clk), .mem_we(mem_we_r), .mem_wdata(mem_wdata_r),
      .preset(preset), .preset_val(preset_val), .mem_rdata(mem_rdata));
   task chk(input string nm, input [15:0] e, input [15:0] g);
      begin
         checked = checked + 1;
         if (e !== g) begin
            n_errors = n_errors + 1;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
         end
      end
   endtask
   // One operation with memory preset, spaced so writes land
   task issue(input [3:0] c, input [7:0] m, input [7:0] x);
      begin
         @(negedge clk); preset = 1; preset_val = m;
         @(negedge clk); preset = 0; op_valid = 1; op_code = c; imm_data = x;
         @(negedge clk); op_valid = 0;
         @(negedge clk);
      end
   endtask
   task t_arith;
      begin
         issue(`ACXU_OP_ADD_I, 8'h00, 8'h7F);
         issue(`ACXU_OP_ADD_I, 8'h00, 8'h01);
         chk("acc", 16'h0080, acc_r);
         chk("flags", 16'h000A, {vf, zf, hf, cf});
         issue(`ACXU_OP_ADD_A, 8'h80, 8'h00);
         chk("acc", 16'h0000, acc_r);
         chk("flags", 16'h000D, {vf, zf, hf, cf});
         issue(`ACXU_OP_ADC_A, 8'h80, 8'h00);
         chk("acc", 16'h0081, acc_r);
         chk("flags", 16'h0000, {vf, zf, hf, cf});
         $display("t_arith done");
      end
   endtask
   task t_mem;
      begin
         issue(`ACXU_OP_ADC_M, 8'h80, 8'h00);
         chk("mem", 16'h0001, mem_rdata);
         chk("acc", 16'h0081, acc_r);
         chk("flags", 16'h0009, {vf, zf, hf, cf});
         issue(`ACXU_OP_AND_M, 8'h03, 8'h00);
         chk("mem", 16'h0001, mem_rdata);
         chk("flags", 16'h0009, {vf, zf, hf, cf});
         issue(`ACXU_OP_ADD_M, 8'h01, 8'h00);
         chk("mem", 16'h0082, mem_rdata);
         chk("flags", 16'h0000, {vf, zf, hf, cf});
         issue(`ACXU_OP_AND_I, 8'h00, 8'h7E);
         chk("flags", 16'h0004, {vf, zf, hf, cf});
         issue(`ACXU_OP_ADD_I, 8'h00, 8'hFF);
         issue(`ACXU_OP_AND_A, 8'h0F, 8'h00);
         chk("acc", 16'h000F, acc_r);
         $display("t_mem done");
      end
   endtask
   // Call at top address, with a refused op in its busy slot
   task t_call;
      begin
         @(negedge clk); op_valid = 1; op_code = `ACXU_OP_CALL;
         pc_in = 13'h1FFF; call_target = 13'h0ABC;
         @(negedge clk); op_code = `ACXU_OP_ADD_I; imm_data = 8'h01;
         chk("push", 16'h0001, stack_push_r);
         chk("ret", 16'h0000, stack_data_r);
         chk("ready", 16'h0000, op_ready);
         @(negedge clk); op_valid = 0;
         chk("load", 16'h0001, pc_load_r);
         chk("target", 16'h0ABC, pc_target_r);
         @(negedge clk);
         chk("acc", 16'h000F, acc_r);
         $display("t_call done");
      end
   endtask
   // Mid-run reset, then carry in on the memory form
   task t_reset;
      begin
         @(negedge clk); arst_n = 0;
         repeat (2) @(negedge clk);
         arst_n = 1;
         issue(`ACXU_OP_ADD_I, 8'h00, 8'h05);
         chk("acc", 16'h0005, acc_r);
         chk("flags", 16'h0000, {vf, zf, hf, cf});
         issue(`ACXU_OP_ADD_I, 8'h00, 8'hFF);
         chk("flags", 16'h0003, {vf, zf, hf, cf});
         issue(`ACXU_OP_ADC_M, 8'h10, 8'h00);
         chk("mem", 16'h0015, mem_rdata);
         chk("acc", 16'h0004, acc_r);
         $display("t_reset done");
      end
   endtask
   task wrap_up;
      begin
         $display("checks %0d mismatches %0d", checked, n_errors);
         if (n_errors == 0 && checked > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   initial begin
      #100000;
      n_errors = n_errors + 1;
      wrap_up;
   end
   initial begin
      repeat (10) @(negedge clk);
      arst_n = 1;
      t_arith;
      t_mem;
      t_call;
      t_reset;
      wrap_up;
   end
endmodule
`default_nettype wire
